// ### design/sensor_cmd_defs.vh
// What this block does
// [RQ1] On a command error, load the result register with a code whose top bit is set.
// [RQ2] Hold an error code until a reset or no-op command; ignore other commands. A new overflow event still replaces a held code.
// [RQ3] Autonomous measurement keeps running while an error is held.
// [RQ4] Without error the result reads 0x00-0x0f; low nibble counts executed commands, wrapping.
// [RQ5] Host confirms each command by watching the rollover counter change.
// [RQ6] Unrecognised command gives the invalid-command code 0x80.
// [RQ7] Proximity channel one, two, three overflow give 0x88, 0x89, 0x8a.
// [RQ8] Visible, infrared and auxiliary overflow give 0x8c, 0x8d, 0x8e.
// [RQ9] Flags: command bit 5, proximity three/two/one bits 4/3/2, ambient 1:0, 7:6 reserved.
// [RQ10] Interrupt output asserts when any flag and its enable bit are both set.
// [RQ11] In mode 0 a set flag stays until the host writes one to its bit.
// [RQ12] In mode 1 flags clear automatically, except proximity channels with mode 11.
// [RQ13] Host reads both visible result bytes after interrupt, before next measurement.
// [RQ14] Only a write to the command register wakes the device from standby.
// [RQ15] In mode 0 writing zero keeps a flag; reading never alters flags.
`ifndef SENSOR_CMD_DEFS_VH
`define SENSOR_CMD_DEFS_VH
`define ADDR_COMMAND_RESULT 8'h20
`define ADDR_INTERRUPT_FLAGS 8'h21
`define ADDR_VIS_LOW 8'h22
`define ADDR_VIS_HIGH 8'h23
`define ADDR_COMMAND 8'h18
`define RESULT_RESET 8'h00
`define FLAGS_RESET 8'h00
`define ERR_INVALID_CMD 8'h80
`define ERR_PROX_ONE 8'h88
`define ERR_PROX_TWO 8'h89
`define ERR_PROX_THREE 8'h8a
`define ERR_VIS 8'h8c
`define ERR_IR 8'h8d
`define ERR_AUX 8'h8e
`define FLAG_CMD_BIT 5
`define FLAG_PROX3_BIT 4
`define FLAG_PROX2_BIT 3
`define FLAG_PROX1_BIT 2
`define FLAG_AMB_HI 1
`define FLAG_AMB_LO 0
`define FLAG_MASK 8'h3f
`define PROX_MODE_KEEP 2'h3
`define CMD_NOP 8'h00
`define CMD_RESET 8'h01
`endif

// ### design/sensor_cmd_response_irq_status.v
`include "sensor_cmd_defs.vh"
module sensor_cmd_response_irq_status (
  input wire clk,
  input wire resetn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg cmd_valid,
  output reg [7:0] cmd_code,
  output reg wake,
  input wire cmd_done,
  input wire cmd_known,
  input wire [6:0] overflow_event,
  input wire [5:0] flag_event,
  input wire [5:0] irq_enable,
  input wire interrupt_mode,
  input wire mode_auto_clear,
  input wire [5:0] proximity_interrupt_mode,
  input wire vis_valid,
  input wire [15:0] vis_data,
  output reg int_out,
  output reg error_held
);
  // ====================
  // Reset release
  reg [1:0] rst_sync_q;
  wire rst_n;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Internal reset follows the second stage only
  assign rst_n = rst_sync_q[1];

  // ====================
  // Decode helpers
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  function clear_code;
    input [7:0] code;
    begin
      clear_code = (code == `CMD_NOP) || (code == `CMD_RESET);
    end
  endfunction

  // Lowest overflow bit wins
  function [7:0] overflow_code;
    input [6:0] ev;
    begin
      if (ev[0]) begin
        overflow_code = `ERR_PROX_ONE;
      end else if (ev[1]) begin
        overflow_code = `ERR_PROX_TWO;
      end else if (ev[2]) begin
        overflow_code = `ERR_PROX_THREE;
      end else if (ev[3]) begin
        overflow_code = `ERR_VIS;
      end else if (ev[4]) begin
        overflow_code = `ERR_IR;
      end else if (ev[5]) begin
        overflow_code = `ERR_AUX;
      end else begin
        overflow_code = `ERR_INVALID_CMD;
      end
    end
  endfunction

  // Proximity flag survives auto clear when its mode is 11
  function [5:0] keep_mask;
    input [5:0] pim;
    begin
      keep_mask = 6'h00;
      keep_mask[`FLAG_PROX1_BIT] = (pim[1:0] == `PROX_MODE_KEEP);
      keep_mask[`FLAG_PROX2_BIT] = (pim[3:2] == `PROX_MODE_KEEP);
      keep_mask[`FLAG_PROX3_BIT] = (pim[5:4] == `PROX_MODE_KEEP);
    end
  endfunction

  // ====================
  // Register strobes
  reg [7:0] result_q, result_d;
  reg pend_q;
  wire is_clear_cmd;
  wire cmd_write;
  wire flag_write;
  wire vis_low_write;
  wire vis_high_write;
  // Error bits above the counter stay zero
  wire [3:0] count_next;

  assign cmd_write = reg_wr && addr_hit(reg_addr, `ADDR_COMMAND);
  assign flag_write = reg_wr && addr_hit(reg_addr, `ADDR_INTERRUPT_FLAGS);
  assign vis_low_write = reg_wr && addr_hit(reg_addr, `ADDR_VIS_LOW);
  assign vis_high_write = reg_wr && addr_hit(reg_addr, `ADDR_VIS_HIGH);
  assign is_clear_cmd = clear_code(reg_wdata);
  assign count_next = result_q[3:0] + 4'h1;

  // ====================
  // Result events
  wire clear_now;
  wire overflow_now;
  wire done_now;

  assign clear_now = cmd_write && result_q[7] && is_clear_cmd;
  assign overflow_now = |overflow_event[5:0];
  assign done_now = cmd_done && pend_q && !result_q[7];

  // ====================
  // Command result
  always @* begin
    result_d = result_q;
    // Clear command zeroes the result only while an error is held
    if (clear_now) begin
      result_d = `RESULT_RESET; // [RQ2]
    end else if (overflow_now) begin
      result_d = overflow_code(overflow_event); // [RQ1] [RQ7] [RQ8]
    end else if (done_now) begin
      if (!cmd_known) begin
        result_d = `ERR_INVALID_CMD; // [RQ6]
      end else begin
        result_d = {4'h0, count_next}; // [RQ4]
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= `RESULT_RESET;
    end else begin
      result_q <= result_d;
    end
  end

  // Mirror of the result's error bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      error_held <= 1'b0;
    end else begin
      error_held <= result_d[7]; // [RQ1]
    end
  end

  // ====================
  // Command handshake
  // Any command register write wakes the sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake <= 1'b0;
    end else begin
      wake <= cmd_write; // [RQ14]
    end
  end

  // Commands are refused while an error is held
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= cmd_write && !result_q[7]; // [RQ2]
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_code <= 8'h00;
    end else if (cmd_write && (!result_q[7] || is_clear_cmd)) begin
      cmd_code <= reg_wdata; // [RQ2]
    end
  end

  // Completion counts only for a command still pending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (cmd_write) begin
      pend_q <= !result_q[7];
    end else if (cmd_done) begin
      pend_q <= 1'b0;
    end
  end

  // ====================
  // Interrupt flags
  reg [5:0] flags_q;
  wire [5:0] flags_d;
  wire [5:0] keep;
  wire auto_clear;

  assign keep = keep_mask(proximity_interrupt_mode);
  assign auto_clear = interrupt_mode && mode_auto_clear;

  // Host write of one clears a flag in mode 0; an event wins
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_flag
      reg flag_d;
      always @* begin
        flag_d = flags_q[g];
        if (!interrupt_mode && flag_write && reg_wdata[g]) begin
          flag_d = 1'b0; // [RQ11] [RQ15]
        end
        if (auto_clear && !keep[g]) begin
          flag_d = 1'b0; // [RQ12]
        end
        if (flag_event[g]) begin
          flag_d = 1'b1; // [RQ9]
        end
      end
      assign flags_d[g] = flag_d;
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= 6'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ====================
  // Interrupt output
  // Follows the next flag state so it rises with the flag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_out <= 1'b0;
    end else begin
      int_out <= |(flags_d & irq_enable); // [RQ10]
    end
  end

  // ====================
  // Visible result bytes
  wire [15:0] vis_q;
  wire [1:0] vis_byte_write;

  assign vis_byte_write = {vis_high_write, vis_low_write};

  // Hardware result wins over a host write in the same cycle
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_vis
      reg [7:0] byte_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          byte_q <= 8'h00;
        end else if (vis_valid) begin
          byte_q <= vis_data[8*g+7 -: 8]; // [RQ3]
        end else if (vis_byte_write[g]) begin
          byte_q <= reg_wdata;
        end
      end
      assign vis_q[8*g+7 -: 8] = byte_q;
    end
  endgenerate

  // ====================
  // Read path
  reg [7:0] rdata_d;

  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `ADDR_COMMAND_RESULT: begin
        rdata_d = result_q; // [RQ4]
      end
      `ADDR_INTERRUPT_FLAGS: begin
        rdata_d = {2'h0, flags_q}; // [RQ9]
      end
      `ADDR_VIS_LOW: begin
        rdata_d = vis_q[7:0];
      end
      `ADDR_VIS_HIGH: begin
        rdata_d = vis_q[15:8];
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // Reads never touch the flags; data holds until the next read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d; // [RQ15]
    end
  end
endmodule // sensor_cmd_response_irq_status

// ### sim/sensor_cmd_props_properties.sv
// ======
// Checker
module sensor_cmd_props (
  input wire clk,
  input wire resetn,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire cmd_valid,
  input wire wake,
  input wire cmd_done,
  input wire cmd_known,
  input wire [6:0] overflow_event,
  input wire [5:0] flag_event,
  input wire [5:0] irq_enable,
  input wire interrupt_mode,
  input wire int_out,
  input wire error_held
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire cw = reg_wr && reg_addr == 8'h18;
  AST_WAKE: assert property (cw |=> wake) else $error("no wake");
  AST_WAKE_SRC: assert property (wake |-> $past(cw)) else $error("stray wake");
  AST_REFUSE: assert property (error_held && cw && reg_wdata > 1 |=> !cmd_valid)
    else $error("refused");
  AST_KEEP: assert property (error_held && !cw && !cmd_valid && !cmd_done |=> error_held)
    else $error("lost error");
  AST_OVF: assert property (|overflow_event[5:0] && !cw |=> error_held) else $error("ovf");
  AST_BAD: assert property (cmd_done && !cmd_known |=> error_held) else $error("bad");
  AST_INT: assert property (|(flag_event & irq_enable) |=> int_out) else $error("int");
  AST_HOLD: assert property (int_out && !interrupt_mode && !reg_wr && $stable(irq_enable)
    |=> int_out) else $error("hold");
  cover property ($rose(error_held));
  cover property ($fell(int_out));
  cover property (wake);
endmodule // sensor_cmd_props
bind sensor_cmd_response_irq_status sensor_cmd_props chk (.*);

// ### sim/sequencer_model.sv
// ======
// Sequencer
module sequencer_model (
  input wire clk,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  output logic cmd_done = 0,
  output logic cmd_known = 1
);
  timeunit 1ns / 1ps;
  always @(negedge clk) if (cmd_valid) begin
    repeat ($urandom % 4) @(negedge clk);
    {cmd_done, cmd_known} <= {1'b1, !cmd_code[7]};
    @(negedge clk) {cmd_done, cmd_known} <= {1'b0, cmd_code[7]};
  end
endmodule // sequencer_model

// ### sim/testbench.sv
// ======
// Bench
module testbench;
  timeunit 1ns / 1ps;
  logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, vis_valid = 0, mode_auto_clear = 0;
  logic interrupt_mode = 0, rd_d = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, exp_q[$];
  logic [6:0] overflow_event = 0;
  logic [5:0] flag_event = 0, irq_enable = 0, proximity_interrupt_mode = 0;
  logic [15:0] vis_data = 0, v;
  wire [7:0] reg_rdata, cmd_code;
  wire cmd_valid, wake, cmd_done, cmd_known, int_out, error_held;
  int n_mismatch = 0, tests_run = 0, i;
  always #2 clk = ~clk;
  sensor_cmd_response_irq_status uut (.*);
  sequencer_model far (.*);
  task chk(logic [7:0] s, x);
    tests_run++;
    n_mismatch += int'(s !== x);
    if (s !== x) $display("Error %0t: got %h want %h", $time, s, x);
  endtask
  task op(logic w, r, logic [7:0] a, d, logic [6:0] o = 0, logic [5:0] f = 0);
    @(negedge clk) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
    {overflow_event, flag_event} <= {o, f};
    if (r) exp_q.push_back(d);
    @(negedge clk) {reg_wr, reg_rd, overflow_event, flag_event} <= 15'h0;
  endtask
  task cmd(logic [7:0] c);
    op(1, 0, 8'h18, c);
    for (int k = 0; k < 9 && !cmd_done; k++) @(negedge clk);
    @(negedge clk);
  endtask
  task tally_and_finish(int extra);
    n_mismatch += extra;
    $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  initial #20000 tally_and_finish(1);
  initial begin
    void'($urandom(32'hf75d76cb));
    repeat (12) @(negedge clk);
    resetn <= 1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 5; i++) op(0, 1, 8'h1f + 8'(i), 0);
    for (i = 0; i < 17; i++) cmd(8'h02 + 8'($urandom % 61));
    op(0, 1, 8'h20, 1);
    cmd(8'h90);
    cmd(8'h05);
    op(0, 1, 8'h20, 8'h80);
    for (i = 0; i < 6; i++) begin
      cmd(8'h01);
      op(0, 0, 0, 0, 7'(1 << i));
      op(0, 1, 8'h20, 8'h88 + 8'(i + i / 3));
    end
    chk(cmd_code, 8'h01);
    v = 16'($urandom);
    @(negedge clk) {vis_valid, vis_data} <= {1'b1, v};
    @(negedge clk) vis_valid <= 0;
    op(0, 1, 8'h22, v[7:0]);
    op(0, 1, 8'h23, v[15:8]);
    chk(error_held, 1);
    irq_enable <= 6'($urandom) | 6'h20;
    op(1, 0, 8'h21, 8'h3f);
    op(0, 0, 0, 0, 0, 6'h20);
    op(1, 0, 8'h21, 0);
    op(0, 1, 8'h21, 8'h20);
    chk(int_out, 1);
    op(1, 0, 8'h21, 8'h20);
    op(0, 1, 8'h21, 0);
    chk(int_out, 0);
    interrupt_mode <= 1;
    proximity_interrupt_mode <= 6'h30;
    op(0, 0, 0, 0, 0, 6'h1c);
    @(negedge clk) mode_auto_clear <= 1;
    @(negedge clk) mode_auto_clear <= 0;
    op(0, 1, 8'h21, 8'h10);
    repeat (2) @(negedge clk);
    tally_and_finish(0);
  end
endmodule // testbench
